// ---- rtl/tic_pkg.sv ----
package tic_pkg;
    // Register byte offsets on the APB window
    localparam logic [7:0] ADDR_IOC_CH0 = 8'h00;
    localparam logic [7:0] ADDR_IOC_CH1 = 8'h04;
    localparam logic [7:0] ADDR_IOC_CH2 = 8'h08;
    localparam logic [7:0] ADDR_MODE_CH0 = 8'h0c;
    localparam logic [7:0] ADDR_IEN_CH0 = 8'h10;
    localparam logic [7:0] ADDR_IEN_CH1 = 8'h14;
    localparam logic [7:0] ADDR_IEN_CH2 = 8'h18;
    localparam logic [7:0] ADDR_PIN_STAT = 8'h1c;
    localparam logic [7:0] ADDR_CAP_CH0 = 8'h20;
    localparam logic [7:0] ADDR_CAP_CH1 = 8'h24;
    localparam logic [7:0] ADDR_CAP_CH2 = 8'h28;

    // Widths
    localparam int CNT_WIDTH = 16;
    localparam int IOC_WIDTH = 4;
    localparam int IEN_BITS = 6;

    // I/O control code fields and reset value
    localparam int IOC_CAPTURE_BIT = 3;
    localparam int IOC_INIT_BIT = 2;
    localparam int IOC_BOTH_BIT = 1;
    localparam logic [3:0] IOC_RESET = 4'h0;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [1:0] CAP_RISE = 2'h0;
    localparam logic [1:0] CAP_FALL = 2'h1;

    // Mode register field
    localparam int MODE_BUFA_BIT = 0;

    // Interrupt enable layout: bit 7 reads 0, bit 6 reads 1
    localparam logic [7:0] IEN_RESET = 8'h40;
    localparam logic [1:0] IEN_TOP_BITS = 2'h1;
    localparam logic [5:0] IEN_MASK_CH0 = 6'h1f;
    localparam logic [5:0] IEN_MASK_CH12 = 6'h33;
    localparam int IEN_UNDERFLOW_BIT = 5;
endpackage

// ---- rtl/tic_chan_if.sv ----
`timescale 1ns/1ps
interface tic_chan_if;
    // Configuration from the register file
    logic [3:0] code;
    logic codeWr;
    logic blocked;
    // Counter side
    logic match;
    logic [15:0] counter;
    // Pin side
    logic pinRaw;
    logic pinOut;
    logic pinOe;
    logic pinLevel;
    // Capture results
    logic capEvt;
    logic [15:0] capValue;

    modport ctrl (
        output code, codeWr, blocked, match, counter, pinRaw,
        input pinOut, pinOe, pinLevel, capEvt, capValue
    );
    modport chan (
        input code, codeWr, blocked, match, counter, pinRaw,
        output pinOut, pinOe, pinLevel, capEvt, capValue
    );
endinterface // tic_chan_if

// ---- rtl/tic_chan_io.sv ----
`timescale 1ns/1ps
module tic_chan_io #(
    parameter bit FORCE_CAPTURE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Channel carrier
    tic_chan_if.chan ch
);
    logic sync0_q;
    logic sync1_q;
    logic prev_q;
    logic [1:0] primed_q;
    logic pinOut_q;
    logic pinOe_q;
    logic capEvt_q;
    logic [15:0] capValue_q;
    wire capMode;
    wire outMode;
    wire active;
    wire riseEdge;
    wire fallEdge;
    wire edgeSel;

    // Mode decode; prohibited codes fall out as neither mode
    assign capMode = ch.code[tic_pkg::IOC_CAPTURE_BIT]
        & (FORCE_CAPTURE | ~ch.code[tic_pkg::IOC_INIT_BIT]);
    assign outMode = ~ch.code[tic_pkg::IOC_CAPTURE_BIT]
        & (ch.code[1:0] != tic_pkg::ACT_NONE);
    assign active = ~ch.blocked;
    // Edges only after the synchroniser has filled; a pin held high through reset still gives one rising edge
    assign riseEdge = primed_q[1] & sync1_q & ~prev_q;
    assign fallEdge = primed_q[1] & ~sync1_q & prev_q;
    assign edgeSel = ch.code[tic_pkg::IOC_BOTH_BIT] ? (riseEdge | fallEdge)
        : (ch.code[1:0] == tic_pkg::CAP_FALL) ? fallEdge
        : riseEdge;

    // Pin synchroniser and edge history
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync0_q <= 1'b0;
            sync1_q <= 1'b0;
            prev_q <= 1'b0;
            primed_q <= 2'h0;
        end
        else
        begin
            sync0_q <= ch.pinRaw;
            sync1_q <= sync0_q;
            prev_q <= sync1_q;
            primed_q <= {primed_q[0], 1'b1};
        end
    end

    // Compare output pin; a code write loads the initial level
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pinOut_q <= 1'b0;
            pinOe_q <= 1'b0;
        end
        else
        begin
            pinOe_q <= outMode & active;
            if (ch.codeWr && outMode)
                pinOut_q <= ch.code[tic_pkg::IOC_INIT_BIT];
            else if (ch.match && outMode && active)
            begin
                unique case (ch.code[1:0])
                    tic_pkg::ACT_LOW: pinOut_q <= 1'b0;
                    tic_pkg::ACT_HIGH: pinOut_q <= 1'b1;
                    tic_pkg::ACT_TOGGLE: pinOut_q <= ~pinOut_q;
                    tic_pkg::ACT_NONE: pinOut_q <= pinOut_q;
                endcase
            end
        end
    end

    // Input capture of the counter
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            capEvt_q <= 1'b0;
            capValue_q <= 16'h0000;
        end
        else
        begin
            capEvt_q <= capMode & active & edgeSel;
            if (capMode && active && edgeSel)
                capValue_q <= ch.counter;
        end
    end

    assign ch.pinOut = pinOut_q;
    assign ch.pinOe = pinOe_q;
    assign ch.pinLevel = sync1_q;
    assign ch.capEvt = capEvt_q;
    assign ch.capValue = capValue_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence capTaken;
        capEvt_q ##0 (capValue_q == $past(ch.counter));
    endsequence

    sequence holdCode;
        $stable(ch.code) && !ch.codeWr;
    endsequence

    init_level_a: assert property (ch.codeWr && outMode |=> pinOut_q == $past(ch.code[2]))
        else $error("initial pin level not loaded");
    low_match_a: assert property (holdCode ##0 (ch.match && outMode && active
        && ch.code[1:0] == 2'h1) |=> !pinOut_q)
        else $error("pin not low after match");
    high_match_a: assert property (holdCode ##0 (ch.match && outMode && active
        && ch.code[1:0] == 2'h2) |=> pinOut_q)
        else $error("pin not high after match");
    disabled_out_a: assert property (!outMode |=> !pinOe_q)
        else $error("pin driven while output disabled");
    rise_cap_a: assert property (capMode && active && ch.code[1:0] == 2'h0
        && riseEdge |=> capTaken)
        else $error("rising edge not captured");
    fall_cap_a: assert property (capMode && active && ch.code[1:0] == 2'h1
        && fallEdge |=> capTaken)
        else $error("falling edge not captured");
    both_cap_a: assert property (capMode && active && ch.code[1] && (riseEdge || fallEdge)
        |=> capTaken)
        else $error("edge missed in both-edge mode");
    buffer_block_a: assert property (ch.blocked |=> !capEvt_q && !pinOe_q)
        else $error("event while used as buffer");
endmodule // tic_chan_io

// ---- rtl/tic_timer_io.sv ----
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module tic_timer_io (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Counter and status side
    input wire logic [2:0][15:0] counterVal,
    input wire logic [2:0] compareMatch,
    input wire logic [2:0][5:0] statusFlag,
    // Timer pins: ch0 register C, ch1 and ch2 register A
    input wire logic [2:0] timerPinIn,
    output logic [2:0] timerPinOut,
    output logic [2:0] timerPinOe,
    // Events
    output logic [2:0] captureEvent,
    output logic [2:0][5:0] irqReq
);
    localparam logic [5:0] IEN_MASK [3] = '{tic_pkg::IEN_MASK_CH0,
        tic_pkg::IEN_MASK_CH12, tic_pkg::IEN_MASK_CH12};

    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [3:0] ioCode_q [3];
    logic [2:0] codeWr_q;
    logic bufA_q;
    logic [5:0] ien_q [3];
    logic [2:0][5:0] irqReq_q;
    wire accessCyc;
    wire wrCommit;
    wire [2:0] selIoc;
    wire [2:0] selIen;
    wire [2:0] selCap;
    wire selMode;
    wire selPin;
    wire hit;
    wire [7:0] ienRd [3];
    wire [2:0] pinLevel;
    wire [15:0] capVal [3];
    wire [31:0] rdData;

    tic_chan_if chIf [3] ();

    // APB phases: one wait state, so read data can come from a register
    assign accessCyc = psel & penable & ~pready_q;
    assign wrCommit = psel & penable & pready_q & pwrite;

    // Address decode
    assign selIoc[0] = paddr == tic_pkg::ADDR_IOC_CH0;
    assign selIoc[1] = paddr == tic_pkg::ADDR_IOC_CH1;
    assign selIoc[2] = paddr == tic_pkg::ADDR_IOC_CH2;
    assign selIen[0] = paddr == tic_pkg::ADDR_IEN_CH0;
    assign selIen[1] = paddr == tic_pkg::ADDR_IEN_CH1;
    assign selIen[2] = paddr == tic_pkg::ADDR_IEN_CH2;
    assign selCap[0] = paddr == tic_pkg::ADDR_CAP_CH0;
    assign selCap[1] = paddr == tic_pkg::ADDR_CAP_CH1;
    assign selCap[2] = paddr == tic_pkg::ADDR_CAP_CH2;
    assign selMode = paddr == tic_pkg::ADDR_MODE_CH0;
    assign selPin = paddr == tic_pkg::ADDR_PIN_STAT;
    assign hit = (|selIoc) | (|selIen) | (|selCap) | selMode | selPin;

    // Enable read view: fixed top bits over the masked store
    assign ienRd[0] = {tic_pkg::IEN_TOP_BITS, ien_q[0]};
    assign ienRd[1] = {tic_pkg::IEN_TOP_BITS, ien_q[1]};
    assign ienRd[2] = {tic_pkg::IEN_TOP_BITS, ien_q[2]};

    // Read multiplexer; unmapped reads return zero
    assign rdData = selIoc[0] ? {28'h0000000, ioCode_q[0]}
        : selIoc[1] ? {28'h0000000, ioCode_q[1]}
        : selIoc[2] ? {28'h0000000, ioCode_q[2]}
        : selMode ? {31'h00000000, bufA_q}
        : selIen[0] ? {24'h000000, ienRd[0]}
        : selIen[1] ? {24'h000000, ienRd[1]}
        : selIen[2] ? {24'h000000, ienRd[2]}
        : selPin ? {20'h00000, 1'b0, pinLevel, 1'b0, timerPinOe, 1'b0, timerPinOut}
        : selCap[0] ? {16'h0000, capVal[0]}
        : selCap[1] ? {16'h0000, capVal[1]}
        : selCap[2] ? {16'h0000, capVal[2]}
        : 32'h00000000;

    // APB handshake and read data
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= accessCyc;
            pslverr_q <= accessCyc & ~hit;
            if (accessCyc && !pwrite)
                prdata_q <= rdData;
        end
    end

    // Buffer-mode bit of the channel 0 mode register
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            bufA_q <= 1'b0;
        else if (wrCommit && selMode)
            bufA_q <= pwdata[tic_pkg::MODE_BUFA_BIT];
    end

    // Code write strobes in one process, so the vector has a single driver
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            codeWr_q <= 3'h0;
        else
            codeWr_q <= selIoc & {3{wrCommit}};
    end

    // Request only while flag and enable are both set
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            irqReq_q <= 18'h00000;
        else
            for (int i = 0; i < 3; i++)
                irqReq_q[i] <= statusFlag[i] & ien_q[i];
    end

    // Per-channel registers and pin logic
    for (genvar c = 0; c < 3; c++)
    begin : g_chan
        // I/O code and enables; the strobe that loads the pin level comes from the shared process above
        always_ff @(posedge ref_clk)
        begin
            if (rst)
            begin
                ioCode_q[c] <= tic_pkg::IOC_RESET;
                ien_q[c] <= tic_pkg::IEN_RESET[5:0];
            end
            else
            begin
                if (wrCommit && selIoc[c])
                    ioCode_q[c] <= pwdata[3:0];
                if (wrCommit && selIen[c])
                    ien_q[c] <= pwdata[5:0] & IEN_MASK[c];
            end
        end

        assign chIf[c].code = ioCode_q[c];
        assign chIf[c].codeWr = codeWr_q[c];
        assign chIf[c].blocked = (c == 0) ? bufA_q : 1'b0;
        assign chIf[c].match = compareMatch[c];
        assign chIf[c].counter = counterVal[c];
        assign chIf[c].pinRaw = timerPinIn[c];
        assign timerPinOut[c] = chIf[c].pinOut;
        assign timerPinOe[c] = chIf[c].pinOe;
        assign pinLevel[c] = chIf[c].pinLevel;
        assign captureEvent[c] = chIf[c].capEvt;
        assign capVal[c] = chIf[c].capValue;

        // Channel 2 ignores bit two once capture is chosen
        tic_chan_io #(
            .FORCE_CAPTURE(c == 2)
        ) u_chan (
            .ref_clk(ref_clk),
            .rst(rst),
            .ch(chIf[c])
        );
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign irqReq = irqReq_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence resetRelease;
        $fell(rst);
    endsequence

    ien_reset_a: assert property (resetRelease |-> ienRd[0] == 8'h40
        && ienRd[1] == 8'h40 && ienRd[2] == 8'h40)
        else $error("enable registers not at reset value");
    ien_top_a: assert property (ienRd[0][7:6] == 2'h1 && ienRd[1][7:6] == 2'h1
        && ienRd[2][7:6] == 2'h1)
        else $error("enable top bits wrong");
    ch0_under_a: assert property (wrCommit && selIen[0] |=> ienRd[0][5] == 1'b0
        && ienRd[0][4:0] == $past(pwdata[4:0]))
        else $error("channel 0 enable write wrong");
    ch12_match_a: assert property (wrCommit && (selIen[1] || selIen[2])
        |=> ienRd[1][3:2] == 2'h0 && ienRd[2][3:2] == 2'h0)
        else $error("channel 1 or 2 reserved enable set");
    irq_gate_a: assert property (1'b1 |=> irqReq_q[0] == ($past(statusFlag[0]) & $past(ien_q[0]))
        && irqReq_q[1] == ($past(statusFlag[1]) & $past(ien_q[1]))
        && irqReq_q[2] == ($past(statusFlag[2]) & $past(ien_q[2])))
        else $error("request not gated by enable");
    code_write_a: assert property (wrCommit && selIoc[0] |=> ioCode_q[0] == $past(pwdata[3:0])
        ##0 codeWr_q[0] ##1 !codeWr_q[0])
        else $error("code write not applied");
    apb_ready_a: assert property (psel && penable && !pready_q |=> pready_q ##1 !pready_q)
        else $error("ready not a single cycle");
    apb_unmapped_a: assert property (accessCyc && !hit |=> pslverr_q && pready_q)
        else $error("unmapped access not flagged");

    // Bus handshake: ready only answers an access, error only with ready
    apb_idle_a: assert property (!(psel && penable) |=> !pready_q)
        else $error("ready without access");
    apb_err_a: assert property (pslverr_q |-> pready_q)
        else $error("error without ready");
    apb_mapped_a: assert property (accessCyc && hit |=> !pslverr_q)
        else $error("mapped access flagged");

    // Read data is taken once per read and then stands
    rd_latch_a: assert property (accessCyc && !pwrite |=> prdata_q == $past(rdData))
        else $error("read data not latched");
    rd_hold_a: assert property (!(accessCyc && !pwrite) |=> $stable(prdata_q))
        else $error("read data moved without read");

    // Code writes on the other channels land with their strobe
    code_ch1_a: assert property (wrCommit && selIoc[1]
        |=> ioCode_q[1] == $past(pwdata[3:0]) && codeWr_q[1])
        else $error("channel 1 code write not applied");
    code_ch2_a: assert property (wrCommit && selIoc[2]
        |=> ioCode_q[2] == $past(pwdata[3:0]) && codeWr_q[2])
        else $error("channel 2 code write not applied");

    // Codes only move on their own write
    code_hold0_a: assert property (!(wrCommit && selIoc[0])
        |=> $stable(ioCode_q[0]))
        else $error("channel 0 code moved");
    code_hold1_a: assert property (!(wrCommit && selIoc[1])
        |=> $stable(ioCode_q[1]))
        else $error("channel 1 code moved");
    code_hold2_a: assert property (!(wrCommit && selIoc[2])
        |=> $stable(ioCode_q[2]))
        else $error("channel 2 code moved");

    // Enable stores keep only the bits that exist
    ien_ch1_a: assert property (wrCommit && selIen[1]
        |=> ienRd[1] == {2'h1, $past(pwdata[5:0]) & 6'h33})
        else $error("channel 1 enable write wrong");
    ien_ch2_a: assert property (wrCommit && selIen[2]
        |=> ienRd[2] == {2'h1, $past(pwdata[5:0]) & 6'h33})
        else $error("channel 2 enable write wrong");
    ien_store_a: assert property (!ien_q[0][5] && ien_q[1][3:2] == 2'h0
        && ien_q[2][3:2] == 2'h0)
        else $error("reserved enable stored");
    ien_hold_a: assert property (!(wrCommit && selIen[0])
        |=> $stable(ien_q[0]))
        else $error("channel 0 enable moved");

    // Requests never show an enable that does not exist
    irq_ch0_a: assert property (!irqReq_q[0][5])
        else $error("channel 0 underflow request");
    irq_ch12_a: assert property (irqReq_q[1][3:2] == 2'h0
        && irqReq_q[2][3:2] == 2'h0)
        else $error("channel 1 or 2 match C/D request");
    irq_off_a: assert property (statusFlag[1] == 6'h00
        |=> irqReq_q[1] == 6'h00)
        else $error("request without flag");
    irq_reset_a: assert property (resetRelease |-> irqReq_q == 18'h00000)
        else $error("request after reset");

    // Buffer mode: the channel 0 path stays quiet, the others never block
    bufa_write_a: assert property (wrCommit && selMode
        |=> bufA_q == $past(pwdata[0]))
        else $error("buffer bit not written");
    buf_quiet_a: assert property (bufA_q
        |=> !captureEvent[0] && !timerPinOe[0])
        else $error("channel 0 active in buffer mode");
    no_block_a: assert property (!chIf[1].blocked && !chIf[2].blocked)
        else $error("channel 1 or 2 blocked");

    // Prohibited and forced codes
    ch0_prohib_a: assert property (ioCode_q[0][3:2] == 2'h3
        |=> !captureEvent[0] && !timerPinOe[0])
        else $error("prohibited channel 0 code active");
    ch2_capture_a: assert property (ioCode_q[2][3]
        |=> !timerPinOe[2])
        else $error("channel 2 drives in capture mode");
endmodule // tic_timer_io

// ---- dv/tic_pin_model.sv ----
`timescale 1ns/1ps
module tic_pin_model (
    // Device drive of the timer pins
    input wire logic [2:0] pinOut,
    input wire logic [2:0] pinOe,
    // Resolved pin levels seen by the device
    output logic [2:0] pinLevel
);
    // Far-side drive, low until a test moves it
    logic [2:0] extLevel = 3'h0;

    // Device wins while it drives; no contention is modelled
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);

    // Called just after a rising edge, so the change lands off the sampling point
    task automatic setLevel(input int ch, input logic v);
        extLevel[ch] <= v;
    endtask
endmodule // tic_pin_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    // Clock, reset and bus drive
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    // Timer side
    logic [2:0][15:0] counterVal = {16'ha5c2, 16'ha5c1, 16'ha5c0};
    logic [2:0] compareMatch = 3'h0;
    logic [2:0][5:0] statusFlag = '0;
    logic [2:0] pinLevel;
    logic [2:0] timerPinOut;
    logic [2:0] timerPinOe;
    logic [2:0] captureEvent;
    logic [2:0][5:0] irqReq;
    // Bookkeeping
    int num_errors = 0;
    int num_checks = 0;
    int capCnt [3] = '{0, 0, 0};
    int base;
    logic [31:0] rdq;
    logic errq;
    logic [3:0] code;
    logic expPin;

    always #5 ref_clk = ~ref_clk;

    tic_timer_io tic_timer_io_i (
        .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .counterVal(counterVal), .compareMatch(compareMatch),
        .statusFlag(statusFlag), .timerPinIn(pinLevel), .timerPinOut(timerPinOut),
        .timerPinOe(timerPinOe), .captureEvent(captureEvent), .irqReq(irqReq)
    );

    tic_pin_model tic_pin_model_i (
        .pinOut(timerPinOut), .pinOe(timerPinOe), .pinLevel(pinLevel)
    );

    // Capture pulses counted per channel
    always @(posedge ref_clk)
    begin
        for (int i = 0; i < 3; i++)
            capCnt[i] += int'(captureEvent[i] === 1'b1);
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // One APB transfer; waits for pready, bounded
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            num_errors++;
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rdq, exp)
        `CHK(errq, 1'b0)
    endtask

    // One high pulse on a pin, then count captures and check the stored value
    task automatic capTest(input int ch, input logic [3:0] c, input int exp);
        wr(tic_pkg::ADDR_IOC_CH0 + 8'(4 * ch), {28'h0, c});
        cyc(6);
        base = capCnt[ch];
        tic_pin_model_i.setLevel(ch, 1'b1);
        cyc(8);
        tic_pin_model_i.setLevel(ch, 1'b0);
        cyc(8);
        `CHK(capCnt[ch] - base, exp)
        if (exp > 0)
            rd(tic_pkg::ADDR_CAP_CH0 + 8'(4 * ch), {16'h0, counterVal[ch]});
    endtask

    task final_report;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Watchdog sized well above the full sequence
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end

    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(3);
        // Reset values
        for (int c = 0; c < 3; c++)
        begin
            rd(tic_pkg::ADDR_IEN_CH0 + 8'(4 * c), 32'h40);
            rd(tic_pkg::ADDR_IOC_CH0 + 8'(4 * c), 32'h0);
        end
        `CHK(timerPinOe, 3'h0)
        // All ones written; only the existing enables stick
        for (int c = 0; c < 3; c++)
            wr(tic_pkg::ADDR_IEN_CH0 + 8'(4 * c), 32'hff);
        rd(tic_pkg::ADDR_IEN_CH0, 32'h5f);
        rd(tic_pkg::ADDR_IEN_CH1, 32'h73);
        rd(tic_pkg::ADDR_IEN_CH2, 32'h73);
        // Requests follow flag and enable together
        statusFlag <= '1;
        cyc(3);
        `CHK(irqReq[0], 6'h1f)
        `CHK(irqReq[1], 6'h33)
        statusFlag[2] <= 6'h0a;
        cyc(3);
        `CHK(irqReq[2], 6'h02)
        wr(tic_pkg::ADDR_IEN_CH1, 32'h0);
        rd(tic_pkg::ADDR_IEN_CH1, 32'h40);
        cyc(2);
        `CHK(irqReq[1], 6'h00)
        // Output codes on every channel, with one compare match each
        for (int c = 0; c < 3; c++)
            for (int k = 0; k < 8; k++)
            begin
                code = 4'(k);
                wr(tic_pkg::ADDR_IOC_CH0 + 8'(4 * c), {28'h0, code});
                cyc(3);
                `CHK(timerPinOe[c], code[1:0] != 2'h0)
                if (code[1:0] != 2'h0) `CHK(timerPinOut[c], code[2])
                compareMatch[c] <= 1'b1;
                cyc(1);
                compareMatch[c] <= 1'b0;
                cyc(3);
                expPin = (code[1:0] == 2'h1) ? 1'b0 : (code[1:0] == 2'h2) ? 1'b1 : ~code[2];
                if (code[1:0] != 2'h0) `CHK(timerPinOut[c], expPin)
            end
        // Capture edge selection
        capTest(1, 4'h8, 1);
        capTest(1, 4'h9, 1);
        capTest(1, 4'ha, 2);
        capTest(1, 4'hb, 2);
        capTest(2, 4'hc, 1);
        capTest(2, 4'hd, 1);
        capTest(0, 4'h8, 1);
        capTest(0, 4'hc, 0);
        // Buffer mode silences the channel 0 register C path
        wr(tic_pkg::ADDR_MODE_CH0, 32'h1);
        capTest(0, 4'h8, 0);
        wr(tic_pkg::ADDR_IOC_CH0, 32'h2);
        cyc(3);
        `CHK(timerPinOe[0], 1'b0)
        // Unmapped address is refused
        apb(1'b1, 8'h30, 32'h1);
        `CHK(errq, 1'b1)
        apb(1'b0, 8'h30, 32'h0);
        `CHK(errq, 1'b1)
        `CHK(rdq, 32'h0)
        final_report();
    end
endmodule // testbench
